// ==== hdl/lvd_defs.svh ====
// constants for the low-voltage detector start-up controller
// Operation
// R1 - mask detector interrupt before enabling
// R2 - bit 2 selects supply or external pin
// R3 - program level bits 3..0 before enable
// R4 - set enable bit 7 after configuration
// R5 - wait 10 us plus pulse width
// R6 - check below-level flag for expected direction
// R7 - clear request flag, then unmask
// R8 - keep mode bit 1 at zero
// R9 - enable interrupts as last step
// R10 - stop by writing zero or clearing enable
// R11 - disable while below level raises request
// R12 - any reset sets the mask
// R13 - start-up may raise a masked request
// R14 - service routine rechecks flag, clears request
// R15 - wait fluctuation period, confirm, clear request
// R16 - reset usage waits fluctuation before port init
// R17 - request on each level crossing
// R18 - bit 0 shows live below-level state
// R19 - comparator registered in the system clock
`ifndef LVD_DEFS_SVH
`define LVD_DEFS_SVH
`define LVD_BIT_ENABLE 7
`define LVD_BIT_SOURCE 2
`define LVD_BIT_MODE 1
`define LVD_BIT_FLAG 0
`define LVD_STAB_NS 10000
`define LVD_CLK_NS 10
`define LVD_CTRL_OFF 8'h00
`define LVD_SYNC_FLUSH 3
`endif

// ==== hdl/lvd_pkg.sv ====
// types for the low-voltage detector start-up controller
package lvd_pkg;
  typedef enum logic [3:0] {
    LVD_IDLE = 4'b0000,
    LVD_MASK = 4'b0001,
    LVD_SRC = 4'b0010,
    LVD_LEVEL = 4'b0011,
    LVD_ENABLE = 4'b0100,
    LVD_WAIT = 4'b0101,
    LVD_CHECK = 4'b0110,
    LVD_CLEAR = 4'b0111,
    LVD_UNMASK = 4'b1000,
    LVD_MODE = 4'b1001,
    LVD_RUN = 4'b1010,
    LVD_SERVICE = 4'b1011,
    LVD_STOP = 4'b1100
  } lvd_state_e;

  // outputs toward the device's detector control
  typedef struct packed {
    logic irq_mask;
    logic irq_clear;
    logic enable;
    logic source_sel;
    logic mode;
    logic [3:0] level_code;
    logic int_enable;
  } lvd_dev_ctrl_s;
endpackage

// ==== hdl/lvd_host_ctrl.sv ====
// host-side start-up and service sequencer for the low-voltage detector
`timescale 1ns/1ps
`include "lvd_defs.svh"
module lvd_host_ctrl
  import lvd_pkg::*;
#(
  parameter int STAB_EXTRA_CYC = 16,
  parameter int SETTLE_CYC = 64
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_use_ext_pin,
  input wire logic i_detect_rising,
  input wire logic [3:0] i_level_code,
  input wire logic i_below_level_flag,
  input wire logic i_detector_irq_request_flag,
  output logic o_detector_irq_mask,
  output logic o_irq_clear,
  output logic o_detector_enable,
  output logic o_source_select,
  output logic o_reset_or_irq_mode,
  output logic [3:0] o_level_code,
  output logic o_enable_interrupts,
  output logic o_busy,
  output logic o_running,
  output logic o_event,
  output logic o_event_below
);
  localparam int STAB_CYC =
    (`LVD_STAB_NS + `LVD_CLK_NS - 1) / `LVD_CLK_NS + STAB_EXTRA_CYC;
  localparam int CNT_W = $clog2(STAB_CYC + SETTLE_CYC + 2);

  typedef struct packed {
    lvd_state_e st;
    lvd_dev_ctrl_s dev;
    logic [CNT_W-1:0] cnt;
    logic flag_m;
    logic flag_s;
    logic req_m;
    logic req_s;
    logic falling_mode;
    logic running;
    logic event_p;
    logic event_below;
  } lvd_host_s;

  lvd_host_s r_q;
  lvd_host_s r_d;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    r_d = r_q;
    r_d.flag_m = i_below_level_flag;
    r_d.flag_s = r_q.flag_m;
    r_d.req_m = i_detector_irq_request_flag;
    r_d.req_s = r_q.req_m;
    r_d.dev.irq_clear = 1'b0;
    r_d.event_p = 1'b0;
    if (r_q.cnt != '0) begin
      r_d.cnt = r_q.cnt - cyc(1);
    end
    case (r_q.st)
      LVD_IDLE: begin
        if (i_start) begin
          r_d.falling_mode = ~i_detect_rising;
          r_d.st = LVD_MASK;
        end
      end
      LVD_MASK: begin
        r_d.dev.irq_mask = 1'b1; // R1
        r_d.dev.int_enable = 1'b0;
        r_d.st = LVD_SRC;
      end
      LVD_SRC: begin
        r_d.dev.source_sel = i_use_ext_pin; // R2
        r_d.dev.mode = 1'b0; // R8
        r_d.st = LVD_LEVEL;
      end
      LVD_LEVEL: begin
        // external pin has a fixed threshold, level left untouched
        if (!r_q.dev.source_sel) begin
          r_d.dev.level_code = i_level_code; // R3
        end
        r_d.st = LVD_ENABLE;
      end
      LVD_ENABLE: begin
        r_d.dev.enable = 1'b1; // R4
        r_d.cnt = cyc(STAB_CYC);
        r_d.st = LVD_WAIT;
      end
      LVD_WAIT: begin
        // the request raised while settling stays masked
        if (r_q.cnt == '0) begin // R5 R13
          r_d.st = LVD_CHECK;
        end
      end
      LVD_CHECK: begin
        // falling detect needs above level, rising needs below
        if (r_q.flag_s != r_q.falling_mode) begin // R6
          r_d.st = LVD_CLEAR;
        end
        if (i_stop) begin
          r_d.st = LVD_STOP;
        end
      end
      LVD_CLEAR: begin
        r_d.dev.irq_clear = 1'b1; // R7
        // synced request lags the clear; ignore it until flushed
        r_d.cnt = cyc(`LVD_SYNC_FLUSH);
        r_d.st = LVD_UNMASK;
      end
      LVD_UNMASK: begin
        r_d.dev.irq_mask = 1'b0; // R7
        r_d.dev.mode = 1'b0; // R8
        r_d.st = LVD_MODE;
      end
      LVD_MODE: begin
        r_d.dev.int_enable = 1'b1; // R9
        r_d.running = 1'b1;
        r_d.st = LVD_RUN;
      end
      LVD_RUN: begin
        if (i_stop) begin
          r_d.st = LVD_STOP;
        end else if (r_q.req_s && (r_q.cnt == '0)) begin
          // hold off through supply fluctuation before recheck
          r_d.cnt = cyc(SETTLE_CYC); // R15
          r_d.st = LVD_SERVICE;
        end
      end
      LVD_SERVICE: begin
        if (r_q.cnt == '0) begin
          r_d.dev.irq_clear = 1'b1; // R14 R15
          r_d.event_p = 1'b1;
          r_d.event_below = r_q.flag_s; // R14
          // stale synced request would retrigger a second service
          r_d.cnt = cyc(`LVD_SYNC_FLUSH);
          r_d.st = LVD_RUN;
        end
      end
      LVD_STOP: begin
        // clears enable, source and mode bits, keeps the level code; a request from stopping
        // while below level is left for software to take
        r_d.dev.enable = 1'b0; // R10 R11
        r_d.dev.source_sel = 1'b0;
        r_d.dev.mode = 1'b0;
        r_d.dev.irq_mask = 1'b1;
        r_d.running = 1'b0;
        r_d.st = LVD_IDLE;
      end
      default: begin
        r_d.st = LVD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r_q <= '0;
      r_q.st <= LVD_IDLE;
      r_q.dev.irq_mask <= 1'b1; // R12
      r_q.falling_mode <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_detector_irq_mask = r_q.dev.irq_mask;
  assign o_irq_clear = r_q.dev.irq_clear;
  assign o_detector_enable = r_q.dev.enable;
  assign o_source_select = r_q.dev.source_sel;
  assign o_reset_or_irq_mode = r_q.dev.mode;
  assign o_level_code = r_q.dev.level_code;
  assign o_enable_interrupts = r_q.dev.int_enable;
  assign o_busy = (r_q.st != LVD_IDLE) && (r_q.st != LVD_RUN);
  assign o_running = r_q.running;
  assign o_event = r_q.event_p;
  assign o_event_below = r_q.event_below;
endmodule

// ==== verification/lvd_host_ctrl_checker.sv ====
// assertions on the detector start-up sequencer ports
`timescale 1ns/1ps
module lvd_host_ctrl_checker #(parameter int STAB_EXTRA_CYC = 16) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic o_detector_irq_mask,
  input wire logic o_irq_clear,
  input wire logic o_detector_enable,
  input wire logic o_source_select,
  input wire logic o_reset_or_irq_mode,
  input wire logic [3:0] o_level_code,
  input wire logic o_enable_interrupts,
  input wire logic o_busy,
  input wire logic o_event
);
  int en_cnt_q;
  // saturates so a long run cannot wrap it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !o_detector_enable) en_cnt_q <= 0;
    else if (en_cnt_q < 4000) en_cnt_q <= en_cnt_q + 1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_mask_before_en: assert property ($rose(o_detector_enable) |->
    o_detector_irq_mask && o_busy) else $error("enable while unmasked");
  a_source_held_on: assert property (o_detector_enable &&
    $past(o_detector_enable) |-> $stable(o_source_select))
    else $error("source moved while on");
  a_level_held_on: assert property (o_detector_enable &&
    $past(o_detector_enable) |-> $stable(o_level_code))
    else $error("level moved while on");
  a_wait_stab: assert property ($fell(o_detector_irq_mask) |->
    en_cnt_q >= 1000 + STAB_EXTRA_CYC) else $error("unmasked too early");
  a_clear_then_unmask: assert property ($fell(o_detector_irq_mask) |->
    $past(o_irq_clear)) else $error("unmask without clear");
  a_mode_irq: assert property (!o_reset_or_irq_mode)
    else $error("mode bit set");
  a_ints_last: assert property ($rose(o_enable_interrupts) |->
    !o_detector_irq_mask && o_detector_enable) else $error("early ints");
  a_stop_whole: assert property ($fell(o_detector_enable) |->
    o_detector_irq_mask && !o_source_select) else $error("partial stop");
  a_event_clear: assert property (o_event |-> o_irq_clear)
    else $error("event without clear");
  c_unmask: cover property ($fell(o_detector_irq_mask));
  c_event: cover property (o_event);
  c_stop: cover property ($fell(o_detector_enable));
endmodule
bind lvd_host_ctrl lvd_host_ctrl_checker #(
  .STAB_EXTRA_CYC(STAB_EXTRA_CYC)) u_chk (.i_sys_clk, .i_rst_n,
  .o_detector_irq_mask, .o_irq_clear, .o_detector_enable, .o_source_select,
  .o_reset_or_irq_mode, .o_level_code, .o_enable_interrupts, .o_busy,
  .o_event);

// ==== verification/lvd_dev_model.sv ====
// behavioural model of the detector and its request flag
`timescale 1ns/1ps
module lvd_dev_model (
  input wire logic i_sys_clk,
  input wire logic i_below,
  input wire logic i_enable,
  input wire logic i_irq_clear,
  output logic o_below_level_flag,
  output logic o_detector_irq_request_flag = 1'b0
);
  logic cmp_q = 1'b0;
  logic en_q = 1'b0;
  assign o_below_level_flag = i_enable & cmp_q;
  always @(posedge i_sys_clk) begin
    cmp_q <= i_below;
    en_q <= i_enable;
    if (i_irq_clear) o_detector_irq_request_flag <= 1'b0;
    else if (i_enable && cmp_q != i_below)
      o_detector_irq_request_flag <= 1'b1;
    else if (en_q && !i_enable && cmp_q)
      o_detector_irq_request_flag <= 1'b1;
  end
endmodule

// ==== verification/low_voltage_detect_interrupt_ctrl_test.sv ====
// self-checking bench for the detector start-up sequencer
`timescale 1ns/1ps
module low_voltage_detect_interrupt_ctrl_test;
  logic clk = 0, rst_n = 0, start = 0, stop = 0, ext = 0, rising = 0;
  logic below = 0, flag, req, mask, clr, en, src, mode, ints, busy, run;
  logic evt, evb;
  logic [3:0] lvl_o;
  int mismatches = 0, tests_run = 0;
  always #5 clk = ~clk;
  lvd_host_ctrl #(.STAB_EXTRA_CYC(1), .SETTLE_CYC(2)) dut (.i_sys_clk(clk),
    .i_rst_n(rst_n), .i_start(start), .i_stop(stop), .i_use_ext_pin(ext),
    .i_detect_rising(rising), .i_level_code(4'hA),
    .i_below_level_flag(flag), .i_detector_irq_request_flag(req),
    .o_detector_irq_mask(mask), .o_irq_clear(clr), .o_detector_enable(en),
    .o_source_select(src), .o_reset_or_irq_mode(mode), .o_level_code(lvl_o),
    .o_enable_interrupts(ints), .o_busy(busy), .o_running(run),
    .o_event(evt), .o_event_below(evb));
  lvd_dev_model dev (.i_sys_clk(clk), .i_below(below), .i_enable(en),
    .i_irq_clear(clr), .o_below_level_flag(flag),
    .o_detector_irq_request_flag(req));
  task check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_for(input bit on_event);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((on_event ? evt : run) === 1'b1) return;
    end
    mismatches++;
    tally_and_finish;
  endtask
  task pulse(input bit is_stop);
    @(posedge clk);
    if (is_stop) stop <= 1'b1;
    else start <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    start <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(mask, 4'h1);
    pulse(0);
    wait_for(0);
    check(en, 4'h1);
    check(src, 4'h0);
    check(lvl_o, 4'hA);
    check(mask, 4'h0);
    check(ints, 4'h1);
    check(mode, 4'h0);
    check(busy, 4'h0);
    @(posedge clk);
    below <= 1'b1;
    wait_for(1);
    check(evb, 4'h1);
    @(negedge clk);
    check(req, 4'h0);
    pulse(1);
    repeat (2) @(negedge clk);
    check(en, 4'h0);
    check(mask, 4'h1);
    @(negedge clk);
    check(req, 4'h1);
    @(posedge clk);
    ext <= 1'b1;
    rising <= 1'b1;
    pulse(0);
    wait_for(0);
    check(src, 4'h1);
    check(mask, 4'h0);
    tally_and_finish;
  end
endmodule
